/* File: verilog/region_decode_pkg.sv */
// package of constants and types for the slave region decoder
`default_nettype none
package region_decode_pkg;
  // ----------------------------------------
  // decode delay limits in clock periods
  // ----------------------------------------
  localparam logic [2:0] DELAY_MIN = 3'h2;
  localparam logic [2:0] DELAY_MAX = 3'h5;
  localparam logic [2:0] DELAY_RESET = 3'h2;
  // ----------------------------------------
  // region inputs by controller mode
  // ----------------------------------------
  localparam int REGION_BITS_IO = 4;
  localparam int REGION_BITS_DRAM = 3;
  localparam int REGION_COUNT = 16;
  // ----------------------------------------
  // local address bus field positions
  // ----------------------------------------
  localparam int AM_LSB = 2;
  localparam int AM_MSB = 7;
  localparam int LA_BIT1 = 1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0] REGION_RESET = 4'h0;
  localparam logic [3:0] BYTEEN_RESET = 4'h0;
  localparam logic [15:0] UNSEL_RESET = 16'h0000;
  // ----------------------------------------
  // decoder states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_DSB = 3'b001,
    ST_COUNT = 3'b010,
    ST_DONE = 3'b011,
    ST_BLOCK = 3'b100
  } decode_state_t;
endpackage : region_decode_pkg
`default_nettype wire

/* File: verilog/vme_slave_region_decode.sv */
// address-phase region decoder of a vme slave interface
`default_nettype none
module vme_slave_region_decode #(
  parameter int REGION_WIDTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic initDone,
  input wire logic [2:0] cfgDecodeDelay,
  input wire logic cfgAmMuxEnable,
  input wire logic cfgDramMode,
  input wire logic [15:0] cfgUnselectedRegions,
  input wire logic addrStrobeN,
  input wire logic second_data_strobeN,
  input wire logic multiplexedCycle,
  input wire logic wideAddrCycle,
  input wire logic blockCycle,
  input wire logic [5:0] addrModifier,
  input wire logic longwordN,
  input wire logic [REGION_WIDTH-1:0] regionSelect,
  input wire logic [7:0] local_address_bus_in,
  output logic [7:0] local_address_bus_out,
  output logic local_address_bus_oe,
  output logic companionLowEnable,
  output logic local_addr_decode_active,
  output logic data_in_enable_lowN,
  output logic data_in_enable_highN,
  output logic [3:0] regionNumber,
  output logic regionValid,
  output logic boardSelected,
  output logic [3:0] data_byte_enables
);
  if (REGION_WIDTH != region_decode_pkg::REGION_BITS_IO) begin : g_width_check
    $error("region input width must be four");
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic [REGION_WIDTH-1:0] regMeta_r;
  logic [REGION_WIDTH-1:0] regSync_r;
  logic [1:0] laMeta_r;
  logic [1:0] laSync_r;
  logic [5:0] syncIn;
  assign syncIn = {blockCycle, wideAddrCycle, multiplexedCycle, ~second_data_strobeN, ~addrStrobeN, initDone};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
      regMeta_r <= '0;
      regSync_r <= '0;
      laMeta_r <= 2'h0;
      laSync_r <= 2'h0;
    end else begin
      meta_r <= syncIn;
      sync_r <= meta_r;
      regMeta_r <= regionSelect;
      regSync_r <= regMeta_r;
      laMeta_r <= {local_address_bus_in[region_decode_pkg::LA_BIT1], longwordN};
      laSync_r <= laMeta_r;
    end
  end
  wire logic asLow = sync_r[1];
  wire logic dsbLow = sync_r[2];
  wire logic muxCyc = sync_r[3];
  wire logic wideCyc = sync_r[4];
  wire logic blkCyc = sync_r[5];
  // ----------------------------------------
  // static configuration capture
  // ----------------------------------------
  logic cfgLoaded_r;
  logic cfgLoaded_nxt;
  logic [2:0] delay_r;
  logic [2:0] delay_nxt;
  logic muxEn_r;
  logic muxEn_nxt;
  logic dram_r;
  logic dram_nxt;
  logic [15:0] unsel_r;
  logic [15:0] unsel_nxt;
  always_comb begin
    cfgLoaded_nxt = cfgLoaded_r;
    delay_nxt = delay_r;
    muxEn_nxt = muxEn_r;
    dram_nxt = dram_r;
    unsel_nxt = unsel_r;
    if (!cfgLoaded_r && sync_r[0]) begin
      cfgLoaded_nxt = 1'b1;
      muxEn_nxt = cfgAmMuxEnable;
      dram_nxt = cfgDramMode;
      unsel_nxt = cfgUnselectedRegions;
      if (cfgDecodeDelay < region_decode_pkg::DELAY_MIN) begin
        delay_nxt = region_decode_pkg::DELAY_MIN;
      end else if (cfgDecodeDelay > region_decode_pkg::DELAY_MAX) begin
        delay_nxt = region_decode_pkg::DELAY_MAX;
      end else begin
        delay_nxt = cfgDecodeDelay;
      end
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfgLoaded_r <= 1'b0;
      delay_r <= region_decode_pkg::DELAY_RESET;
      muxEn_r <= 1'b0;
      dram_r <= 1'b0;
      unsel_r <= region_decode_pkg::UNSEL_RESET;
    end else begin
      cfgLoaded_r <= cfgLoaded_nxt;
      delay_r <= delay_nxt;
      muxEn_r <= muxEn_nxt;
      dram_r <= dram_nxt;
      unsel_r <= unsel_nxt;
    end
  end
  // ----------------------------------------
  // decode sequencer
  // ----------------------------------------
  region_decode_pkg::decode_state_t state_r;
  region_decode_pkg::decode_state_t state_nxt;
  logic [2:0] count_r;
  logic [2:0] count_nxt;
  logic active_r;
  logic active_nxt;
  logic handover_r;
  logic handover_nxt;
  logic [3:0] region_r;
  logic [3:0] region_nxt;
  logic valid_r;
  logic valid_nxt;
  logic sel_r;
  logic sel_nxt;
  logic [3:0] byteEn_r;
  logic [3:0] byteEn_nxt;
  logic [1:0] data_in_enable_low_r;
  logic [1:0] data_in_enable_low_nxt;
  logic [2:0] handDly_r;
  logic [2:0] handDly_nxt;
  wire logic [3:0] sampled = dram_r ? {1'b0, regSync_r[2:0]} : regSync_r;
  function automatic logic [3:0] byte_enables(input logic addr1, input logic lwordN);
    if (!lwordN) begin
      byte_enables = 4'hF;
    end else if (addr1) begin
      byte_enables = 4'h3;
    end else begin
      byte_enables = 4'hC;
    end
  endfunction : byte_enables
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    active_nxt = active_r;
    handover_nxt = handover_r;
    region_nxt = region_r;
    valid_nxt = valid_r;
    sel_nxt = sel_r;
    byteEn_nxt = byteEn_r;
    data_in_enable_low_nxt = 2'h0;
    handDly_nxt = {handDly_r[1:0], handover_r};
    case (state_r)
      region_decode_pkg::ST_IDLE: begin
        if (asLow && cfgLoaded_r) begin
          active_nxt = 1'b1;
          count_nxt = 3'h1;
          if (muxCyc) begin
            state_nxt = region_decode_pkg::ST_WAIT_DSB;
          end else begin
            state_nxt = region_decode_pkg::ST_COUNT;
          end
        end
      end
      region_decode_pkg::ST_WAIT_DSB: begin
        handover_nxt = 1'b1;
        data_in_enable_low_nxt = wideCyc ? 2'h3 : 2'h0;
        if (!asLow) begin
          state_nxt = region_decode_pkg::ST_IDLE;
        end else if (dsbLow) begin
          count_nxt = 3'h1;
          state_nxt = region_decode_pkg::ST_COUNT;
        end
      end
      region_decode_pkg::ST_COUNT: begin
        handover_nxt = 1'b1;
        if (!asLow) begin
          state_nxt = region_decode_pkg::ST_IDLE;
        end else if (count_r >= delay_r - 3'h1) begin
          region_nxt = sampled;
          valid_nxt = 1'b1;
          sel_nxt = ~unsel_r[sampled];
          state_nxt = region_decode_pkg::ST_DONE;
        end else begin
          count_nxt = count_r + 3'h1;
        end
      end
      region_decode_pkg::ST_DONE: begin
        if (!asLow) begin
          state_nxt = region_decode_pkg::ST_IDLE;
        end else if (blkCyc && !dsbLow) begin
          state_nxt = region_decode_pkg::ST_BLOCK;
        end
      end
      region_decode_pkg::ST_BLOCK: begin
        if (!asLow) begin
          state_nxt = region_decode_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = region_decode_pkg::ST_IDLE;
      end
    endcase
    if (state_nxt == region_decode_pkg::ST_IDLE) begin
      active_nxt = 1'b0;
      handover_nxt = 1'b0;
      valid_nxt = 1'b0;
      sel_nxt = 1'b0;
      count_nxt = 3'h0;
    end
    // low byte reaches the synchroniser output two clocks after hand-over
    if (handDly_r == 3'h3) begin
      byteEn_nxt = byte_enables(laSync_r[1], laSync_r[0]);
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= region_decode_pkg::ST_IDLE;
      count_r <= 3'h0;
      active_r <= 1'b0;
      handover_r <= 1'b0;
      region_r <= region_decode_pkg::REGION_RESET;
      valid_r <= 1'b0;
      sel_r <= 1'b0;
      byteEn_r <= region_decode_pkg::BYTEEN_RESET;
      data_in_enable_low_r <= 2'h0;
      handDly_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      active_r <= active_nxt;
      handover_r <= handover_nxt;
      region_r <= region_nxt;
      valid_r <= valid_nxt;
      sel_r <= sel_nxt;
      byteEn_r <= byteEn_nxt;
      data_in_enable_low_r <= data_in_enable_low_nxt;
      handDly_r <= handDly_nxt;
    end
  end
  // ----------------------------------------
  // local address drive
  // ----------------------------------------
  logic [7:0] laOut_r;
  logic [7:0] laOut_nxt;
  logic laOe_r;
  logic laOe_nxt;
  always_comb begin
    laOut_nxt = 8'h00;
    laOe_nxt = 1'b0;
    if (muxEn_r && cfgLoaded_r && !handover_nxt) begin
      laOut_nxt[region_decode_pkg::AM_MSB:region_decode_pkg::AM_LSB] = addrModifier;
      laOe_nxt = 1'b1;
    end else if (!muxEn_r && state_nxt == region_decode_pkg::ST_BLOCK) begin
      laOut_nxt = local_address_bus_in;
      laOe_nxt = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      laOut_r <= 8'h00;
      laOe_r <= 1'b0;
    end else begin
      laOut_r <= laOut_nxt;
      laOe_r <= laOe_nxt;
    end
  end
  assign local_address_bus_out = laOut_r;
  assign local_address_bus_oe = laOe_r;
  assign companionLowEnable = ~laOe_r;
  assign local_addr_decode_active = active_r;
  assign data_in_enable_lowN = ~data_in_enable_low_r[0];
  assign data_in_enable_highN = ~data_in_enable_low_r[1];
  assign regionNumber = region_r;
  assign regionValid = valid_r;
  assign boardSelected = sel_r;
  assign data_byte_enables = byteEn_r;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_active_ends: assert property (@(posedge clock) disable iff (!resetn)
    (state_r != region_decode_pkg::ST_IDLE && !asLow) |=> !local_addr_decode_active)
    else $error("decode active not dropped at end of cycle");
  a_handover_one: assert property (@(posedge clock) disable iff (!resetn)
    $rose(local_addr_decode_active) && muxEn_r |=> (!local_address_bus_oe || !asLow))
    else $error("drivers not released one clock after decode active");
  a_mux_gate: assert property (@(posedge clock) disable iff (!resetn)
    !muxEn_r |-> (!local_address_bus_oe || state_r == region_decode_pkg::ST_BLOCK))
    else $error("address driven with multiplexing off");
  a_delay_range: assert property (@(posedge clock) disable iff (!resetn)
    delay_r >= region_decode_pkg::DELAY_MIN && delay_r <= region_decode_pkg::DELAY_MAX)
    else $error("decode delay out of range");
  a_cfg_static: assert property (@(posedge clock) disable iff (!resetn)
    cfgLoaded_r |=> $stable(delay_r) && $stable(muxEn_r))
    else $error("configuration changed after init");
  a_unsel_quiet: assert property (@(posedge clock) disable iff (!resetn)
    regionValid |-> (boardSelected == ~unsel_r[regionNumber]))
    else $error("unselected region answered");
  a_dram_three: assert property (@(posedge clock) disable iff (!resetn)
    (regionValid && dram_r) |-> !regionNumber[3])
    else $error("fourth region bit used in dram mode");
  a_sample_time: assert property (@(posedge clock) disable iff (!resetn)
    ($rose(local_addr_decode_active) && !muxCyc && delay_r == 3'h2) |=> ##1 (regionValid || !asLow))
    else $error("region not sampled at decode delay");
  c_decode: cover property (@(posedge clock) disable iff (!resetn) $rose(regionValid));
  c_muxcyc: cover property (@(posedge clock) disable iff (!resetn) state_r == region_decode_pkg::ST_WAIT_DSB);
  c_block: cover property (@(posedge clock) disable iff (!resetn) state_r == region_decode_pkg::ST_BLOCK);
endmodule : vme_slave_region_decode
`default_nettype wire

/* File: verif/region_decoder_model.sv */
// far-side model: external region decoder and low-byte address companion
`default_nettype none
module region_decoder_model (
  input wire logic clock,
  input wire logic addrStrobeN,
  input wire logic [3:0] busRegion,
  input wire logic [7:1] busAddr,
  input wire logic longwordN,
  input wire logic [7:0] local_address_bus_out,
  input wire logic companionLowEnable,
  input wire logic local_addr_decode_active,
  output logic [3:0] regionSelect,
  output logic [7:0] local_address_bus_in,
  output logic [5:0] amSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic activeQ = 1'b0;
  logic [7:0] lastLow = 8'h00;
  initial amSeen = 6'h00;
  // region compare result, stable from strobe low, junk between cycles
  assign regionSelect = addrStrobeN ? ~busRegion : busRegion;
  // companion passes address 7..1 and longword, otherwise a toggling pattern
  assign local_address_bus_in = companionLowEnable ? {busAddr, longwordN} : ~lastLow;
  always @(posedge clock) begin
    activeQ <= local_addr_decode_active;
    lastLow <= local_address_bus_in;
    if (local_addr_decode_active && !activeQ) amSeen <= local_address_bus_out[7:2];
  end
endmodule : region_decoder_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking testbench for the slave region decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic initDone = 1'b0;
  logic [2:0] cfgDecodeDelay = 3'h2;
  logic cfgAmMuxEnable = 1'b0;
  logic cfgDramMode = 1'b0;
  logic [15:0] cfgUnselectedRegions = 16'h0000;
  logic addrStrobeN = 1'b1;
  logic second_data_strobeN = 1'b1;
  logic multiplexedCycle = 1'b0;
  logic wideAddrCycle = 1'b0;
  logic [5:0] addrModifier = 6'h0D;
  logic longwordN = 1'b1;
  logic blockCycle = 1'b0;
  logic [3:0] busRegion = 4'h0;
  logic [7:1] busAddr = 7'h00;
  logic [3:0] regionSelect;
  logic [7:0] laIn;
  logic [7:0] local_address_bus_out;
  logic [5:0] amSeen;
  logic local_address_bus_oe, companionLowEnable, local_addr_decode_active;
  logic data_in_enable_lowN, data_in_enable_highN, regionValid, boardSelected;
  logic [3:0] regionNumber;
  logic [3:0] data_byte_enables;
  int miscompares = 0;
  int tests_run = 0;
  int lat;
  int ov;
  always #10 clock = ~clock;
  vme_slave_region_decode #(.REGION_WIDTH(4)) vme_slave_region_decode_inst (
    .clock(clock), .resetn(resetn), .initDone(initDone), .cfgDecodeDelay(cfgDecodeDelay),
    .cfgAmMuxEnable(cfgAmMuxEnable), .cfgDramMode(cfgDramMode), .cfgUnselectedRegions(cfgUnselectedRegions),
    .addrStrobeN(addrStrobeN), .second_data_strobeN(second_data_strobeN), .multiplexedCycle(multiplexedCycle),
    .wideAddrCycle(wideAddrCycle), .blockCycle(blockCycle), .addrModifier(addrModifier), .longwordN(longwordN),
    .regionSelect(regionSelect), .local_address_bus_in(laIn), .local_address_bus_out(local_address_bus_out),
    .local_address_bus_oe(local_address_bus_oe), .companionLowEnable(companionLowEnable),
    .local_addr_decode_active(local_addr_decode_active), .data_in_enable_lowN(data_in_enable_lowN),
    .data_in_enable_highN(data_in_enable_highN), .regionNumber(regionNumber), .regionValid(regionValid),
    .boardSelected(boardSelected), .data_byte_enables(data_byte_enables));
  region_decoder_model region_decoder_model_inst (
    .clock(clock), .addrStrobeN(addrStrobeN), .busRegion(busRegion), .busAddr(busAddr),
    .longwordN(longwordN), .local_address_bus_out(local_address_bus_out),
    .companionLowEnable(companionLowEnable), .local_addr_decode_active(local_addr_decode_active),
    .regionSelect(regionSelect), .local_address_bus_in(laIn), .amSeen(amSeen));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // reset, load configuration, then finish init
  task automatic start(logic [2:0] d, logic m, logic dr, logic [15:0] u);
    @(negedge clock);
    resetn = 1'b0;
    initDone = 1'b0;
    cfgDecodeDelay = d;
    cfgAmMuxEnable = m;
    cfgDramMode = dr;
    cfgUnselectedRegions = u;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    initDone = 1'b1;
    repeat (5) @(negedge clock);
  endtask : start
  // one slave address phase with expected region, selection and byte enables
  task automatic cycle(logic [3:0] r, logic [7:1] a, logic lw, logic mx, logic [3:0] er, logic sel,
                       logic [3:0] be);
    busRegion = r;
    busAddr = a;
    longwordN = lw;
    multiplexedCycle = mx;
    wideAddrCycle = mx;
    addrStrobeN = 1'b0;
    for (int i = 0; mx && i < 8; i++) begin
      @(negedge clock);
      if (i > 3) check("dataInEnable", 2'h0, {data_in_enable_lowN, data_in_enable_highN});
      check("earlyValid", 1'h0, regionValid);
    end
    second_data_strobeN = 1'b0;
    lat = 0;
    ov = 0;
    for (int n = 0; n < 12; n++) begin
      @(negedge clock);
      if (local_addr_decode_active === 1'b1 && regionValid !== 1'b1) lat++;
      if (local_addr_decode_active === 1'b1 && local_address_bus_oe === 1'b1) ov++;
    end
    check("boardSelected", sel, boardSelected);
    check("regionValid", 1'h1, regionValid);
    check("regionNumber", er, regionNumber);
    check("byteEnables", be, data_byte_enables);
    check("ownDriveOff", 2'h1, {local_address_bus_oe, companionLowEnable});
    addrStrobeN = 1'b1;
    second_data_strobeN = 1'b1;
    repeat (4) @(negedge clock);
    check("activeEnd", 2'h0, {local_addr_decode_active, regionValid});
    repeat (2) @(negedge clock);
  endtask : cycle
  task automatic t_idle();
    start(3'h2, 1'b1, 1'b0, 16'h0000);
    check("idleAm", {1'b1, addrModifier}, {local_address_bus_oe, local_address_bus_out[7:2]});
    addrModifier = 6'h39;
    repeat (2) @(negedge clock);
    check("idleAmNew", 6'h39, local_address_bus_out[7:2]);
    start(3'h2, 1'b0, 1'b0, 16'h0000);
    check("muxOffIdle", 2'h1, {local_address_bus_oe, companionLowEnable});
    $display("t_idle done");
  endtask : t_idle
  task automatic t_delay();
    for (int d = 2; d <= 5; d++) begin
      start(3'(d), 1'b1, 1'b0, 16'h0000);
      cfgDecodeDelay = 3'h7;
      addrModifier = 6'(6'h08 + d);
      cycle(4'h5, 7'h02, 1'b1, 1'b0, 4'h5, 1'b1, 4'hC);
      check("latency", 16'(d - 1), 16'(lat));
      check("handOver", 16'h1, 16'(ov));
      check("amLatched", 16'(6'h08 + d), amSeen);
    end
    $display("t_delay done");
  endtask : t_delay
  task automatic t_bytes();
    start(3'h3, 1'b0, 1'b0, 16'h0000);
    cycle(4'h2, 7'h01, 1'b0, 1'b0, 4'h2, 1'b1, 4'hF);
    cycle(4'h2, 7'h01, 1'b1, 1'b0, 4'h2, 1'b1, 4'h3);
    cycle(4'h2, 7'h7E, 1'b1, 1'b0, 4'h2, 1'b1, 4'hC);
    $display("t_bytes done");
  endtask : t_bytes
  task automatic t_regions();
    start(3'h2, 1'b0, 1'b0, 16'h0100);
    cycle(4'hF, 7'h00, 1'b1, 1'b0, 4'hF, 1'b1, 4'hC);
    cycle(4'h8, 7'h00, 1'b1, 1'b0, 4'h8, 1'b0, 4'hC);
    start(3'h2, 1'b0, 1'b1, 16'h0000);
    cycle(4'hF, 7'h00, 1'b1, 1'b0, 4'h7, 1'b1, 4'hC);
    $display("t_regions done");
  endtask : t_regions
  // block transfer: own drive only once the first beat's data strobe is released
  task automatic t_block();
    start(3'h2, 1'b0, 1'b0, 16'h0000);
    blockCycle = 1'b1;
    busRegion = 4'h6;
    busAddr = 7'h00;
    longwordN = 1'b1;
    multiplexedCycle = 1'b0;
    wideAddrCycle = 1'b0;
    addrStrobeN = 1'b0;
    second_data_strobeN = 1'b0;
    repeat (8) @(negedge clock);
    check("firstBeatDrive", 2'h1, {local_address_bus_oe, companionLowEnable});
    second_data_strobeN = 1'b1;
    repeat (4) @(negedge clock);
    check("laterBeatDrive", 2'h2, {local_address_bus_oe, companionLowEnable});
    check("blockRegion", 5'h16, {regionValid, regionNumber});
    addrStrobeN = 1'b1;
    repeat (4) @(negedge clock);
    check("blockEnd", 3'h1, {local_addr_decode_active, local_address_bus_oe, companionLowEnable});
    blockCycle = 1'b0;
    repeat (2) @(negedge clock);
    $display("t_block done");
  endtask : t_block
  task automatic t_mux();
    start(3'h2, 1'b1, 1'b0, 16'h0000);
    cycle(4'h3, 7'h00, 1'b1, 1'b1, 4'h3, 1'b1, 4'hC);
    check("dataInEnableOff", 2'h3, {data_in_enable_lowN, data_in_enable_highN});
    $display("t_mux done");
  endtask : t_mux
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    t_idle();
    t_delay();
    t_bytes();
    t_regions();
    t_block();
    t_mux();
    conclude();
  end
endmodule : tb
`default_nettype wire
